// File: dispatch_serialization_control.sv
// Implementation choices: the address-and-strobe port and the register addresses.
module dispatch_serialization_control #(
  parameter int LIST_DEPTH   = 8,
  parameter int SETTLE_DEPTH = 8
) (
  input  logic                                        SYS_CLK,
  input  logic                                        RESET_N,
  input  logic                                        CE,
  input  logic [dispatch_serial_pkg::ADDR_W-1:0]      ADDR,
  input  logic [dispatch_serial_pkg::DATA_W-1:0]      WDATA,
  input  logic                                        WR,
  input  logic                                        RD,
  output logic [dispatch_serial_pkg::DATA_W-1:0]      RDATA,
  input  logic                                        FETCH_VALID,
  input  dispatch_serial_pkg::op_type                 FETCH_OP,
  input  logic [dispatch_serial_pkg::SPR_W-1:0]       FETCH_SPR,
  input  logic                                        FETCH_LINK,
  output logic                                        FETCH_ACCEPT,
  output logic                                        PREFETCH_DISCARD,
  output logic                                        REFETCH,
  input  logic                                        XLATE_REQ,
  output logic                                        XLATE_GO,
  output logic                                        DISP_VALID,
  output dispatch_serial_pkg::op_type                 DISP_OP,
  output logic [dispatch_serial_pkg::SPR_W-1:0]       DISP_SPR,
  input  logic                                        LIST_RETIRE,
  input  logic                                        SETTLE_DONE,
  input  logic                                        CACHE_DONE,
  input  logic                                        SPR_RETURN,
  input  logic [dispatch_serial_pkg::SPR_W-1:0]       SPR_RETURN_IDX
);
  import dispatch_serial_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic [NUM_SPR-1:0] spr_bit(input logic [SPR_W-1:0] idx);
    spr_bit = {{(NUM_SPR-1){1'b0}}, 1'b1} << idx;
  endfunction

  function automatic logic [NUM_SPR-1:0] need_free(input op_type op,
                                                   input logic [SPR_W-1:0] idx,
                                                   input logic lk);
    need_free = '0;
    case (op)
      OP_SPR_TO, OP_SPR_FROM:
        need_free = spr_bit(idx);
      OP_SUPER_CALL:
        need_free = spr_bit(SPR_COUNT) | spr_bit(SPR_STATE) | (lk ? spr_bit(SPR_LINK) : '0);
      OP_INT_RETURN:
        need_free = spr_bit(SPR_SAVED_PC) | spr_bit(SPR_SAVED_STATE) | spr_bit(SPR_STATE);
      OP_CALL_RETURN:
        need_free = spr_bit(SPR_LINK) | spr_bit(SPR_COUNT) | spr_bit(SPR_STATE);
      OP_STATE_MOVE:
        need_free = spr_bit(SPR_STATE);
      default:
        need_free = '0;
    endcase
  endfunction

  function automatic logic in_list(input op_type op);
    in_list = (op == OP_LOAD) || (op == OP_STORE) || (op == OP_TRAP);
  endfunction

  function automatic logic is_cache(input op_type op);
    is_cache = (op == OP_LINE_FLUSH) || (op == OP_LINE_STORE) || (op == OP_LINE_ZERO);
  endfunction

  function automatic logic is_settle(input op_type op);
    is_settle = is_cache(op) || (op == OP_DATA_SYNC) || (op == OP_XLATE_INVAL) ||
                (op == OP_SEG_MOVE) || (op == OP_LINE_INVAL);
  endfunction

  function automatic logic is_serial(input op_type op);
    is_serial = (op == OP_SUPER_CALL) || (op == OP_INT_RETURN) || (op == OP_CALL_RETURN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  ctl_state_type           state;
  ctl_state_type           next_state;
  logic [NUM_SPR-1:0]      spr_lock;
  logic [CNT_W-1:0]        list_cnt;
  logic [CNT_W-1:0]        settle_cnt;
  logic [CNT_W-1:0]        cache_cnt;
  logic [CNT_W-1:0]        dcs_wait;
  logic                    dcs_lock;
  logic                    hold;
  logic [SYNC_CNT_W-1:0]   sync_count;

  ////////////////////////////////////////////////////////////////////////////
  // Dispatch decision
  wire                     sync_clear;
  wire                     locks_ok;
  wire                     list_full;
  wire                     settle_full;
  wire                     room_ok;
  wire                     serial_ok;
  wire                     take;
  wire                     take_ics;
  wire                     take_dcs;
  wire                     take_state;
  wire                     take_serial;
  wire                     sync_done;
  wire                     state_release;

  assign sync_clear  = (list_cnt == '0) && (settle_cnt == '0) && !dcs_lock;
  assign locks_ok    = (need_free(FETCH_OP, FETCH_SPR, FETCH_LINK) & spr_lock) == '0;
  assign list_full   = list_cnt == CNT_W'(LIST_DEPTH);
  assign settle_full = settle_cnt == CNT_W'(SETTLE_DEPTH);
  assign room_ok     = !(in_list(FETCH_OP) && list_full) && !(is_settle(FETCH_OP) && settle_full);
  assign serial_ok   = !is_serial(FETCH_OP) || sync_clear;
  assign take        = (state == ST_RUN) && FETCH_VALID && !FETCH_ACCEPT && !hold &&
                       locks_ok && room_ok && serial_ok;
  assign take_ics    = take && (FETCH_OP == OP_FETCH_SYNC);
  assign take_dcs    = take && (FETCH_OP == OP_DATA_SYNC);
  assign take_state  = take && (FETCH_OP == OP_STATE_MOVE);
  assign take_serial = take && is_serial(FETCH_OP);
  assign sync_done     = (state == ST_SYNC_WAIT) && sync_clear;
  assign state_release = (state == ST_STATE_WAIT) && !spr_lock[SPR_STATE];

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (take_ics)
          next_state = ST_SYNC_WAIT;
        else if (take_state)
          next_state = ST_STATE_WAIT;
      end
      ST_SYNC_WAIT:
      begin
        if (sync_done)
          next_state = ST_RUN;
      end
      ST_STATE_WAIT:
      begin
        if (state_release)
          next_state = ST_RUN;
      end
      default:
        next_state = ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interlocks and counters
  wire [NUM_SPR-1:0]       spr_set;
  wire [NUM_SPR-1:0]       spr_clr;
  wire [NUM_SPR-1:0]       next_spr_lock;
  wire                     list_dec;
  wire                     settle_dec;
  wire                     cache_dec;
  wire                     dcs_dec;
  wire [CNT_W-1:0]         cache_left;
  wire [CNT_W-1:0]         next_list_cnt;
  wire [CNT_W-1:0]         next_settle_cnt;
  wire [CNT_W-1:0]         next_cache_cnt;
  wire [CNT_W-1:0]         next_dcs_wait;
  wire                     next_dcs_lock;

  assign spr_set = (take && (FETCH_OP == OP_SPR_TO)) ? spr_bit(FETCH_SPR) :
                   take_state ? spr_bit(SPR_STATE) : '0;
  assign spr_clr       = SPR_RETURN ? spr_bit(SPR_RETURN_IDX) : '0;
  assign next_spr_lock = (spr_lock & ~spr_clr) | spr_set;

  assign list_dec      = LIST_RETIRE && (list_cnt != '0);
  assign next_list_cnt = list_cnt + CNT_W'(take && in_list(FETCH_OP)) - CNT_W'(list_dec);
  assign settle_dec      = SETTLE_DONE && (settle_cnt != '0);
  assign next_settle_cnt = settle_cnt + CNT_W'(take && is_settle(FETCH_OP)) - CNT_W'(settle_dec);
  assign cache_dec       = CACHE_DONE && (cache_cnt != '0);
  assign next_cache_cnt  = cache_cnt + CNT_W'(take && is_cache(FETCH_OP)) - CNT_W'(cache_dec);

  assign cache_left    = cache_cnt - CNT_W'(cache_dec);
  assign dcs_dec       = cache_dec && (dcs_wait != '0);
  assign next_dcs_wait = take_dcs ? cache_left : dcs_wait - CNT_W'(dcs_dec);
  assign next_dcs_lock = take_dcs ? 1'b1 : (dcs_lock && (dcs_wait == '0)) ? 1'b0 : dcs_lock;

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state      <= ST_RUN;
      spr_lock   <= '0;
      list_cnt   <= '0;
      settle_cnt <= '0;
      cache_cnt  <= '0;
      dcs_wait   <= '0;
      dcs_lock   <= 1'b0;
    end
    else if (CE)
    begin
      state      <= next_state;
      spr_lock   <= next_spr_lock;
      list_cnt   <= next_list_cnt;
      settle_cnt <= next_settle_cnt;
      cache_cnt  <= next_cache_cnt;
      dcs_wait   <= next_dcs_wait;
      dcs_lock   <= next_dcs_lock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dispatch and fetch outputs
  wire                     pt_locked;
  wire                     next_discard;
  wire                     next_refetch;
  wire                     next_xlate;

  assign next_discard = take_ics || take_serial || state_release;
  assign next_refetch = sync_done || take_serial || state_release;
  assign pt_locked  = spr_lock[SPR_PT_LO] || spr_lock[SPR_PT_HI];
  assign next_xlate = XLATE_REQ && !pt_locked && !spr_set[SPR_PT_LO] && !spr_set[SPR_PT_HI];

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      FETCH_ACCEPT     <= 1'b0;
      PREFETCH_DISCARD <= 1'b0;
      REFETCH          <= 1'b0;
      XLATE_GO         <= 1'b0;
      DISP_VALID       <= 1'b0;
      DISP_OP          <= OP_OTHER;
      DISP_SPR         <= '0;
    end
    else if (CE)
    begin
      FETCH_ACCEPT     <= take;
      PREFETCH_DISCARD <= next_discard;
      REFETCH          <= next_refetch;
      XLATE_GO         <= next_xlate;
      DISP_VALID       <= take && !take_ics;
      DISP_OP          <= take ? FETCH_OP : DISP_OP;
      DISP_SPR         <= take ? FETCH_SPR : DISP_SPR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  wire                     wr_ctrl;
  wire                     busy;
  wire [DATA_W-1:0]        status_word;
  wire [DATA_W-1:0]        read_mux;

  assign wr_ctrl     = WR && (ADDR == ADDR_CTRL);
  assign busy        = state != ST_RUN;
  assign status_word = {{(DATA_W-STAT_SETTLE_LSB-CNT_W){1'b0}}, settle_cnt,
                        {(STAT_SETTLE_LSB-STAT_LIST_LSB-CNT_W){1'b0}}, list_cnt,
                        {(STAT_LIST_LSB-STAT_BUSY_BIT-1){1'b0}}, busy, dcs_lock, spr_lock};
  assign read_mux    = (ADDR == ADDR_CTRL)   ? {{(DATA_W-1){1'b0}}, hold} :
                       (ADDR == ADDR_STATUS) ? status_word :
                       (ADDR == ADDR_SYNCS)  ? {{(DATA_W-SYNC_CNT_W){1'b0}}, sync_count} : '0;

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      hold       <= HOLD_RESET;
      sync_count <= '0;
      RDATA      <= '0;
    end
    else if (CE)
    begin
      hold       <= wr_ctrl ? WDATA[0] : hold;
      sync_count <= sync_count + SYNC_CNT_W'(sync_done);
      RDATA      <= RD ? read_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence ics_in;
    CE && take_ics;
  endsequence

  sequence sync_finish;
    CE && sync_done;
  endsequence

  sequence dcs_in;
    CE && take_dcs;
  endsequence

  sequence call_in;
    CE && take && (FETCH_OP == OP_SUPER_CALL);
  endsequence

  AST_ICS_DISCARD: assert property (ics_in |=> PREFETCH_DISCARD && (state == ST_SYNC_WAIT))
    else $error("fetch sync did not discard prefetch");
  AST_LIST_WAIT: assert property (CE && (state == ST_SYNC_WAIT) && (list_cnt != '0)
                                  |=> !REFETCH && (state == ST_SYNC_WAIT))
    else $error("fetch sync left with list not empty");
  AST_SETTLE_WAIT: assert property (CE && (state == ST_SYNC_WAIT) && (settle_cnt != '0)
                                    |=> state == ST_SYNC_WAIT)
    else $error("fetch sync left with unsettled ops");
  AST_SYNC_FREEZE: assert property (CE && (state == ST_SYNC_WAIT) |=> !DISP_VALID && !FETCH_ACCEPT)
    else $error("dispatch during fetch sync");
  AST_SYNC_REFETCH: assert property (sync_finish |=> REFETCH && (state == ST_RUN))
    else $error("no refetch after fetch sync");
  AST_DCS_HOLD: assert property (CE && dcs_lock && (dcs_wait != '0) && !take_dcs |=> dcs_lock)
    else $error("data sync ended before line ops");
  AST_DCS_FLOW: assert property (dcs_in |=> FETCH_ACCEPT && DISP_VALID && dcs_lock)
    else $error("data sync stalled or missed interlock");
  AST_CALL_SERIAL: assert property (call_in |=> DISP_VALID && PREFETCH_DISCARD && REFETCH)
    else $error("supervisor call not serialized");
  AST_STATE_BLOCK: assert property (CE && (state == ST_STATE_WAIT) && spr_lock[SPR_STATE]
                                    |=> !DISP_VALID && (state == ST_STATE_WAIT))
    else $error("dispatch before state update");
  AST_STATE_REFETCH: assert property (CE && state_release |=> PREFETCH_DISCARD && REFETCH)
    else $error("no refetch after state update");
  AST_SPR_CLEAR: assert property (CE && SPR_RETURN && !take |=> !spr_lock[$past(SPR_RETURN_IDX)])
    else $error("interlock not cleared on return");
  AST_XLATE_GATE: assert property (CE && pt_locked |=> !XLATE_GO)
    else $error("translation during descriptor move");

endmodule

// File: dispatch_serial_pkg.sv
package dispatch_serial_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Operation classes presented by fetch
  typedef enum logic [4:0] {
    OP_OTHER,
    OP_LOAD,
    OP_STORE,
    OP_TRAP,
    OP_FETCH_SYNC,
    OP_DATA_SYNC,
    OP_XLATE_INVAL,
    OP_SEG_MOVE,
    OP_LINE_INVAL,
    OP_LINE_FLUSH,
    OP_LINE_STORE,
    OP_LINE_ZERO,
    OP_SUPER_CALL,
    OP_INT_RETURN,
    OP_CALL_RETURN,
    OP_STATE_MOVE,
    OP_SPR_TO,
    OP_SPR_FROM
  } op_type;

  typedef enum {
    ST_RUN,
    ST_SYNC_WAIT,
    ST_STATE_WAIT
  } ctl_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Special registers held in the dispatch unit
  localparam int         NUM_SPR          = 7;
  localparam int         SPR_W            = 3;
  localparam logic [2:0] SPR_LINK         = 3'h0;
  localparam logic [2:0] SPR_COUNT        = 3'h1;
  localparam logic [2:0] SPR_STATE        = 3'h2;
  localparam logic [2:0] SPR_SAVED_PC     = 3'h3;
  localparam logic [2:0] SPR_SAVED_STATE  = 3'h4;
  localparam logic [2:0] SPR_PT_LO        = 3'h5;
  localparam logic [2:0] SPR_PT_HI        = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int         ADDR_W           = 4;
  localparam int         DATA_W           = 32;
  localparam int         CNT_W            = 4;
  localparam int         SYNC_CNT_W       = 16;
  localparam logic [3:0] ADDR_CTRL        = 4'h0;
  localparam logic [3:0] ADDR_STATUS      = 4'h4;
  localparam logic [3:0] ADDR_SYNCS       = 4'h8;
  localparam int         STAT_BUSY_BIT    = 8;
  localparam int         STAT_LIST_LSB    = 16;
  localparam int         STAT_SETTLE_LSB  = 24;
  localparam logic       HOLD_RESET       = 1'b0;

endpackage

// File: fxu_model.sv
module fxu_model
(
  input  logic                                  clk,
  input  logic                                  rst_n,
  input  logic                                  hold,
  input  logic                                  disp_valid,
  input  dispatch_serial_pkg::op_type           disp_op,
  input  logic [dispatch_serial_pkg::SPR_W-1:0] disp_spr,
  output logic                                  list_retire,
  output logic                                  settle_done,
  output logic                                  cache_done,
  output logic                                  spr_return,
  output logic [dispatch_serial_pkg::SPR_W-1:0] spr_return_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  import dispatch_serial_pkg::*;

  int               list_n;
  int               settle_n;
  int               cache_n;
  logic [SPR_W-1:0] spr_q[$];
  logic             go;

  ////////////////////////////////////////////////////////////
  // Each outstanding count and the return queue drain one item per cycle unless held
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      list_n = 0;
      settle_n = 0;
      cache_n = 0;
      spr_q.delete();
      list_retire <= 1'b0;
      settle_done <= 1'b0;
      cache_done <= 1'b0;
      spr_return <= 1'b0;
      spr_return_idx <= '0;
    end
    else
    begin
      go = !hold;
      list_retire <= go && list_n > 0;
      if (go && list_n > 0)
        list_n--;
      settle_done <= go && settle_n > 0;
      if (go && settle_n > 0)
        settle_n--;
      cache_done <= go && cache_n > 0;
      if (go && cache_n > 0)
        cache_n--;
      spr_return <= go && spr_q.size() > 0;
      // Idle index flips to the inverse of its last value each cycle, which can itself be a valid index
      if (go && spr_q.size() > 0)
        spr_return_idx <= spr_q.pop_front();
      else
        spr_return_idx <= ~spr_return_idx;
      if (disp_valid && disp_op inside {OP_LOAD, OP_STORE, OP_TRAP})
        list_n++;
      if (disp_valid && disp_op inside {OP_DATA_SYNC, OP_XLATE_INVAL, OP_SEG_MOVE, OP_LINE_INVAL})
        settle_n++;
      if (disp_valid && disp_op inside {OP_LINE_FLUSH, OP_LINE_STORE, OP_LINE_ZERO})
      begin
        settle_n++;
        cache_n++;
      end
      if (disp_valid && disp_op == OP_SPR_TO)
        spr_q.push_back(disp_spr);
      if (disp_valid && disp_op == OP_STATE_MOVE)
        spr_q.push_back(SPR_STATE);
    end
  end
endmodule

// File: dispatch_serialization_control_test.sv
module dispatch_serialization_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dispatch_serial_pkg::*;

  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              fvalid = 1'b0;
  op_type            fop = OP_OTHER;
  logic [SPR_W-1:0]  fspr = '0;
  logic              flink = 1'b0;
  logic              xreq = 1'b0;
  logic              fx_hold = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              faccept, pdisc, refetch, xgo, dvalid, lret, sdone, cdone, sret;
  op_type            dop;
  logic [SPR_W-1:0]  dspr;
  logic [SPR_W-1:0]  sidx;
  logic              last_dv;
  op_type            last_dop;
  logic [SPR_W-1:0]  last_ds;
  int                errors = 0;
  int                num_checks = 0;
  int                pd_n = 0;
  int                rf_n = 0;

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    pd_n += (pdisc === 1'b1);
    rf_n += (refetch === 1'b1);
  end

  dispatch_serialization_control uut (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .FETCH_VALID(fvalid), .FETCH_OP(fop), .FETCH_SPR(fspr), .FETCH_LINK(flink),
    .FETCH_ACCEPT(faccept), .PREFETCH_DISCARD(pdisc), .REFETCH(refetch), .XLATE_REQ(xreq),
    .XLATE_GO(xgo), .DISP_VALID(dvalid), .DISP_OP(dop), .DISP_SPR(dspr), .LIST_RETIRE(lret),
    .SETTLE_DONE(sdone), .CACHE_DONE(cdone), .SPR_RETURN(sret), .SPR_RETURN_IDX(sidx));

  fxu_model fxu (
    .clk(sys_clk), .rst_n(reset_n), .hold(fx_hold), .disp_valid(dvalid), .disp_op(dop),
    .disp_spr(dspr), .list_retire(lret), .settle_done(sdone), .cache_done(cdone),
    .spr_return(sret), .spr_return_idx(sidx));

  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask

  // Waits for the take; the instruction is withdrawn at the edge ending the accept cycle
  task automatic take(input int lim, input logic exp);
    logic got;
    got = 1'b0;
    for (int n = 0; n < lim && !got; n++)
    begin
      @(posedge sys_clk);
      #1;
      got = (faccept === 1'b1);
      last_dv = dvalid;
      last_dop = dop;
      last_ds = dspr;
    end
    chk("accept", exp, got);
    if (exp && !got)
      conclude();
    if (got)
    begin
      @(posedge sys_clk);
      fvalid <= 1'b0;
      #1;
    end
  endtask

  task automatic put(input op_type op, input logic [SPR_W-1:0] s, input logic lk, input int lim,
                     input logic exp);
    @(posedge sys_clk);
    fvalid <= 1'b1;
    fop <= op;
    fspr <= s;
    flink <= lk;
    take(lim, exp);
    if (exp)
      chk("disp_valid", op != OP_FETCH_SYNC, last_dv);
    if (exp && last_dv)
      chk("disp_op", op, last_dop);
    if (exp && last_dv)
      chk("disp_spr", s, last_ds);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(ADDR_STATUS, 32'h0000_0000);
    rd_chk(ADDR_SYNCS, 32'h0000_0000);
    rd_chk(4'hc, 32'h0000_0000);
    wr_reg(ADDR_STATUS, 32'hffff_ffff);
    rd_chk(ADDR_STATUS, 32'h0000_0000);
    wr_reg(ADDR_CTRL, 32'h0000_0001);
    rd_chk(ADDR_CTRL, 32'h0000_0001);
    put(OP_OTHER, SPR_LINK, 1'b0, 5, 1'b0);
    wr_reg(ADDR_CTRL, 32'h0000_0000);
    take(5, 1'b1);
    // Clock enable low loses the write
    ce <= 1'b0;
    wr_reg(ADDR_CTRL, 32'h0000_0001);
    ce <= 1'b1;
    rd_chk(ADDR_CTRL, 32'h0000_0000);
  endtask

  task automatic t_fsync();
    int pd0;
    int rf0;
    fx_hold <= 1'b1;
    put(OP_LOAD, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_LINE_FLUSH, SPR_LINK, 1'b0, 4, 1'b1);
    pd0 = pd_n;
    rf0 = rf_n;
    put(OP_FETCH_SYNC, SPR_LINK, 1'b0, 4, 1'b1);
    chk("discard", 1, pd_n - pd0);
    put(OP_OTHER, SPR_LINK, 1'b0, 8, 1'b0);
    rd_chk(ADDR_STATUS, 32'h0101_0100);
    chk("refetch", 0, rf_n - rf0);
    fx_hold <= 1'b0;
    take(20, 1'b1);
    chk("refetch", 1, rf_n - rf0);
    rd_chk(ADDR_SYNCS, 32'h0000_0001);
  endtask

  task automatic t_dsync();
    int pd0;
    pd0 = pd_n;
    fx_hold <= 1'b1;
    put(OP_LINE_STORE, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_DATA_SYNC, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_OTHER, SPR_LINK, 1'b0, 3, 1'b1);
    rd_chk(ADDR_STATUS, 32'h0200_0080);
    chk("discard", 0, pd_n - pd0);
    put(OP_FETCH_SYNC, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_OTHER, SPR_LINK, 1'b0, 6, 1'b0);
    fx_hold <= 1'b0;
    take(20, 1'b1);
  endtask

  task automatic t_spr();
    fx_hold <= 1'b1;
    put(OP_SPR_TO, SPR_LINK, 1'b0, 4, 1'b1);
    rd_chk(ADDR_STATUS, 32'h0000_0001);
    put(OP_OTHER, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_SPR_FROM, SPR_LINK, 1'b0, 6, 1'b0);
    fx_hold <= 1'b0;
    take(10, 1'b1);
    rd_chk(ADDR_STATUS, 32'h0000_0000);
    fx_hold <= 1'b1;
    put(OP_SPR_TO, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_SUPER_CALL, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_SUPER_CALL, SPR_LINK, 1'b1, 6, 1'b0);
    fx_hold <= 1'b0;
    take(10, 1'b1);
  endtask

  task automatic t_serial();
    op_type           ops[5] = '{OP_INT_RETURN, OP_INT_RETURN, OP_CALL_RETURN, OP_CALL_RETURN, OP_SUPER_CALL};
    logic [SPR_W-1:0] regs[5] = '{SPR_SAVED_PC, SPR_SAVED_STATE, SPR_LINK, SPR_COUNT, SPR_COUNT};
    int               pd0;
    int               rf0;
    for (int i = 0; i < 5; i++)
    begin
      fx_hold <= 1'b1;
      put(OP_SPR_TO, regs[i], 1'b0, 4, 1'b1);
      put(ops[i], SPR_LINK, 1'b0, 6, 1'b0);
      pd0 = pd_n;
      fx_hold <= 1'b0;
      take(10, 1'b1);
      chk("discard", 1, pd_n - pd0);
    end
    fx_hold <= 1'b1;
    put(OP_STATE_MOVE, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_OTHER, SPR_LINK, 1'b0, 6, 1'b0);
    pd0 = pd_n;
    rf0 = rf_n;
    fx_hold <= 1'b0;
    take(10, 1'b1);
    chk("discard", 1, pd_n - pd0);
    chk("refetch", 1, rf_n - rf0);
  endtask

  task automatic t_full();
    fx_hold <= 1'b1;
    for (int i = 0; i < 8; i++)
      put(i[0] ? OP_TRAP : OP_STORE, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_LOAD, SPR_LINK, 1'b0, 6, 1'b0);
    rd_chk(ADDR_STATUS, 32'h0008_0000);
    fx_hold <= 1'b0;
    take(10, 1'b1);
  endtask

  task automatic t_reset();
    fx_hold <= 1'b1;
    put(OP_SPR_TO, SPR_COUNT, 1'b0, 4, 1'b1);
    put(OP_LINE_FLUSH, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_DATA_SYNC, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_LOAD, SPR_LINK, 1'b0, 4, 1'b1);
    rd_chk(ADDR_STATUS, 32'h0201_0082);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    fx_hold <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd_chk(ADDR_STATUS, 32'h0000_0000);
    put(OP_SPR_FROM, SPR_COUNT, 1'b0, 4, 1'b1);
  endtask

  task automatic t_xlate();
    int pd0;
    fx_hold <= 1'b1;
    @(posedge sys_clk);
    xreq <= 1'b1;
    put(OP_SPR_TO, SPR_PT_HI, 1'b0, 4, 1'b1);
    pd0 = pd_n;
    put(OP_SEG_MOVE, SPR_LINK, 1'b0, 4, 1'b1);
    chk("xlate_go", 0, xgo);
    chk("discard", 0, pd_n - pd0);
    fx_hold <= 1'b0;
    for (int n = 0; n < 10 && xgo !== 1'b1; n++)
      @(posedge sys_clk) #1;
    chk("xlate_go", 1, xgo);
    if (xgo !== 1'b1)
      conclude();
    put(OP_XLATE_INVAL, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_FETCH_SYNC, SPR_LINK, 1'b0, 4, 1'b1);
    put(OP_OTHER, SPR_LINK, 1'b0, 20, 1'b1);
    rd_chk(ADDR_SYNCS, 32'h0000_0003);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs();
    t_fsync();
    t_dsync();
    t_spr();
    t_serial();
    t_full();
    t_xlate();
    t_reset();
    conclude();
  end
endmodule
